// *** rtl/ccsr_pkg.sv ***
package ccsr_pkg;

  // ----------------------------------------
  // Target address and register map
  // ----------------------------------------
  localparam logic [6:0] DEV_ADDR      = 7'h36;
  localparam logic [7:0] OFS_STATUS    = 8'h00;
  localparam logic [7:0] OFS_CTRL_A    = 8'h01;
  localparam logic [7:0] OFS_CTRL_B    = 8'h02;
  localparam logic [7:0] OFS_EVENTS    = 8'h03;

  // ----------------------------------------
  // Values after reset and field masks
  // ----------------------------------------
  localparam logic [7:0] CTRL_A_RST    = 8'h51;
  localparam logic [7:0] CTRL_B_RST    = 8'h1E;
  localparam logic [7:0] EVENTS_RST    = 8'h00;
  localparam logic [7:0] CTRL_A_STORE  = 8'h7D;
  localparam logic [7:0] EVENTS_VALID  = 8'h3D;

  // ----------------------------------------
  // Bit positions
  // ----------------------------------------
  localparam int B_SOFT_RST     = 7;
  localparam int B_CHG_ALLOW    = 6;
  localparam int B_BOOST_REQ    = 5;
  localparam int B_THERM_EN     = 4;
  localparam int B_TJ_DERATE    = 3;
  localparam int B_FORCE_EOC    = 2;
  localparam int B_TMR_RESTART  = 1;
  localparam int B_IRQ_MASK     = 0;
  localparam int B_WDOG_OFF     = 7;
  localparam int B_CTMR_OFF     = 6;
  localparam int B_ROUTE_EN     = 5;
  localparam int B_XCVR_EN      = 4;
  localparam int B_FLAG_MASK    = 3;
  localparam int B_LIM_PINSEL   = 2;
  localparam int B_LIM_EN       = 1;
  localparam int B_ADAPT_EN     = 0;
  localparam int B_VBUS_OK      = 0;

  // ----------------------------------------
  // Charge and boost state codes
  // ----------------------------------------
  localparam logic [3:0] ST_OFF        = 4'h0;
  localparam logic [3:0] ST_WAIT       = 4'h1;
  localparam logic [3:0] ST_WEAK_WAIT  = 4'h8;
  localparam logic [3:0] ST_WEAK_SAFE  = 4'h9;
  localparam logic [3:0] ST_WEAK_CHG   = 4'hA;
  localparam logic [3:0] ST_FAULT      = 4'hB;
  localparam logic [3:0] ST_BST_WAIT   = 4'hC;
  localparam logic [3:0] ST_BST_RUN    = 4'hD;
  localparam logic [3:0] ST_BST_FAULT  = 4'hE;
  localparam logic [3:0] ST_BST_OVLD   = 4'hF;

  localparam logic [3:0] LAST_DATA_BIT = 4'h7;
  localparam logic [3:0] ACK_SLOT      = 4'h8;

endpackage : ccsr_pkg

// *** rtl/ccsr_line_if.sv ***
interface ccsr_line_if;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;
  logic sda;

  modport det (
    output scl_rise,
    output scl_fall,
    output start,
    output stop,
    output sda
  );
  modport fsm (
    input  scl_rise,
    input  scl_fall,
    input  start,
    input  stop,
    input  sda
  );
endinterface : ccsr_line_if

// *** rtl/ccsr_sync.sv ***
module ccsr_sync #(
  parameter int W = 1
) (
  input  wire logic         mclk_i,
  input  wire logic         rstn_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta;

  // Idle-high reset so a released bus does not look like a start
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      meta <= '1;
      q_o  <= '1;
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end
endmodule : ccsr_sync

// *** rtl/ccsr_line_det.sv ***
module ccsr_line_det (
  input  wire logic  mclk_i,
  input  wire logic  rstn_i,
  input  wire logic  scl_s_i,
  input  wire logic  sda_s_i,
  ccsr_line_if.det   line
);
  logic scl_q;
  logic sda_q;

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_s_i;
      sda_q <= sda_s_i;
    end
  end

  assign line.scl_rise = scl_s_i & ~scl_q;
  assign line.scl_fall = ~scl_s_i & scl_q;
  assign line.start    = scl_s_i & scl_q & sda_q & ~sda_s_i;
  assign line.stop     = scl_s_i & scl_q & ~sda_q & sda_s_i;
  assign line.sda      = sda_s_i;
endmodule : ccsr_line_det

// *** rtl/ccsr_regs.sv ***
module ccsr_regs (
  input  wire logic       mclk_i,
  input  wire logic       rstn_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_o,
  input  wire logic       boost_pin_i,
  input  wire logic       off_state_i,
  input  wire logic       charge_mode_enter_i,
  input  wire logic       boost_mode_enter_i,
  input  wire logic [3:0] charge_state_i,
  input  wire logic       batfet_present_i,
  input  wire logic       thermistor_present_i,
  input  wire logic       fault_event_pending_i,
  input  wire logic [7:0] status_event_set_i,
  output logic            charging_allow_o,
  output logic            host_boost_request_o,
  output logic            thermistor_profile_en_o,
  output logic            junction_heat_derate_o,
  output logic            force_end_of_charge_o,
  output logic            charge_timer_restart_o,
  output logic            watchdog_off_o,
  output logic            charge_timer_off_o,
  output logic            power_route_enable_o,
  output logic            transceiver_supply_en_o,
  output logic            input_limit_pin_select_o,
  output logic            input_limit_enable_o,
  output logic            adaptive_input_current_enable_o,
  output logic            irq_pin_n_o,
  output logic            flag_event_o
);
  // Overview of operation
  // R1: Answer as bus target at 7-bit address 0x36 (bytes 0x6C/0x6D).
  // R2: Status bits 7..4 report the charge state code.
  // R3: In boost mode the state field reports codes 1100 to 1111.
  // R4: Status bit 3 shows an isolation transistor is present.
  // R5: Status bit 2 shows a battery thermistor is present.
  // R6: Status bit 1 is set while any status event is pending.
  // R7: Status bit 0 is set while any fault event is pending.
  // R8: Writing 1 to control A bit 7 restores all defaults.
  // R9: Control A bit 6, default 1, allows charging.
  // R10: Control A bit 5 requests boost; pin sets it, charge entry clears.
  // R11: Control A bit 4, default 1, lets temperature shape charging.
  // R12: Control A bit 3 derates current on high junction temperature.
  // R13: Control A bit 2 forces end of charge.
  // R14: Control A bit 1 restarts the charge timer and self-clears.
  // R15: Control A bit 0, default 1, masks the interrupt pin.
  // R16: Control B bits 7 and 6 disable watchdog and charge timer.
  // R17: Control B bit 5 enables power path management.
  // R18: Control B bit 4, default 1, supplies the transceiver pin.
  // R19: Control B bit 3, default 1, masks the flag pin.
  // R20: Control B bit 2, default 1, takes input limit from pins.
  // R21: Control B bit 1, default 1, enables the input current limit.
  // R22: Control B bit 0 enables adaptive input current control.
  // R23: Write: pointer byte first, data stored at incrementing offsets.
  // R24: Read returns data from the pointer, auto-incrementing.
  // R25: Event bits clear on read; interrupt pin low while any pending.
  // R26: Reserved bits read zero and ignore writes.

  typedef enum logic [2:0] {
    IDLE,
    ADDR,
    PTR,
    WR,
    RD
  } ccsr_i2c_st_t;

  // ----------------------------------------
  // Pin synchronisers and line conditions
  // ----------------------------------------
  logic [1:0]   bus_s;
  logic         boost_s;
  logic         boost_q;
  ccsr_line_if  line ();

  ccsr_sync #(.W(2)) u_bus_sync (
    .mclk_i (mclk_i),
    .rstn_i (rstn_i),
    .d_i    ({scl_i, sda_i}),
    .q_o    (bus_s)
  );

  ccsr_sync #(.W(1)) u_boost_sync (
    .mclk_i (mclk_i),
    .rstn_i (rstn_i),
    .d_i    (boost_pin_i),
    .q_o    (boost_s)
  );

  ccsr_line_det u_det (
    .mclk_i  (mclk_i),
    .rstn_i  (rstn_i),
    .scl_s_i (bus_s[1]),
    .sda_s_i (bus_s[0]),
    .line    (line)
  );

  // ----------------------------------------
  // Register storage and read mux
  // ----------------------------------------
  ccsr_i2c_st_t st;
  logic [3:0]   cnt;
  logic [7:0]   shreg;
  logic [7:0]   tx;
  logic [7:0]   ptr;
  logic         rw;
  logic         mack;
  logic         wr_stb;
  logic [7:0]   wr_addr;
  logic [7:0]   wr_data;
  logic         rd_stb;
  logic [7:0]   rd_addr;
  logic [7:0]   ctrl_a;
  logic [7:0]   ctrl_b;
  logic [7:0]   events;
  logic [7:0]   status_word;
  logic [7:0]   rd_word;
  logic         any_pending;
  logic         soft_rst;
  logic         to_default;
  logic         boost_rise;
  logic         addr_hit;

  assign status_word = {charge_state_i,                 // R2 R3
                        batfet_present_i,               // R4
                        thermistor_present_i,           // R5
                        |events,                        // R6
                        fault_event_pending_i};         // R7

  always_comb begin
    case (ptr)
      ccsr_pkg::OFS_STATUS: rd_word = status_word;
      ccsr_pkg::OFS_CTRL_A: rd_word = ctrl_a;
      ccsr_pkg::OFS_CTRL_B: rd_word = ctrl_b;
      ccsr_pkg::OFS_EVENTS: rd_word = events;
      default:              rd_word = 8'h00;
    endcase
  end

  assign addr_hit = (shreg[7:1] == ccsr_pkg::DEV_ADDR);

  // ----------------------------------------
  // Bus target state machine
  // ----------------------------------------
  // Open drain: only ever pulls low
  assign sda_o = 1'b0;

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      st       <= IDLE;
      cnt      <= 4'h0;
      shreg    <= 8'h00;
      tx       <= 8'h00;
      ptr      <= 8'h00;
      rw       <= 1'b0;
      mack     <= 1'b0;
      sda_oe_o <= 1'b0;
      wr_stb   <= 1'b0;
      wr_addr  <= 8'h00;
      wr_data  <= 8'h00;
      rd_stb   <= 1'b0;
      rd_addr  <= 8'h00;
    end else begin
      wr_stb <= 1'b0;
      rd_stb <= 1'b0;
      if (line.start) begin
        st       <= ADDR;
        // The SCL fall that closes START wraps this to zero, not one
        cnt      <= 4'hF;
        sda_oe_o <= 1'b0;
      end else if (line.stop) begin
        st       <= IDLE;
        sda_oe_o <= 1'b0;
      end else if (st != IDLE) begin
        if (line.scl_rise) begin
          if (cnt != ccsr_pkg::ACK_SLOT && st != RD) begin
            shreg <= {shreg[6:0], line.sda};
          end
          if (cnt == ccsr_pkg::ACK_SLOT) begin
            mack <= ~line.sda;
          end
        end else if (line.scl_fall) begin
          if (cnt == ccsr_pkg::LAST_DATA_BIT) begin
            cnt      <= ccsr_pkg::ACK_SLOT;
            sda_oe_o <= (st != RD);
            case (st)
              ADDR: begin
                rw <= shreg[0];
                if (!addr_hit) begin                    // R1
                  st       <= IDLE;
                  sda_oe_o <= 1'b0;
                end
              end
              PTR: begin
                ptr <= shreg;                           // R23 R24
              end
              WR: begin
                wr_stb  <= 1'b1;
                wr_addr <= ptr;
                wr_data <= shreg;
                ptr     <= ptr + 8'h01;                 // R23
              end
              default: begin
              end
            endcase
          end else if (cnt == ccsr_pkg::ACK_SLOT) begin
            cnt      <= 4'h0;
            sda_oe_o <= 1'b0;
            case (st)
              ADDR: begin
                if (rw) begin
                  st       <= RD;
                  tx       <= rd_word;                  // R24
                  sda_oe_o <= ~rd_word[7];
                  rd_stb   <= 1'b1;
                  rd_addr  <= ptr;
                  ptr      <= ptr + 8'h01;
                end else begin
                  st <= PTR;
                end
              end
              PTR: st <= WR;
              RD: begin
                if (mack) begin
                  tx       <= rd_word;                  // R24
                  sda_oe_o <= ~rd_word[7];
                  rd_stb   <= 1'b1;
                  rd_addr  <= ptr;
                  ptr      <= ptr + 8'h01;
                end else begin
                  st <= IDLE;
                end
              end
              default: begin
              end
            endcase
          end else begin
            cnt <= cnt + 4'h1;
            if (st == RD) begin
              tx       <= {tx[6:0], 1'b0};
              sda_oe_o <= ~tx[6];
            end else begin
              sda_oe_o <= 1'b0;
            end
          end
        end
      end
    end
  end

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  assign soft_rst = wr_stb && wr_addr == ccsr_pkg::OFS_CTRL_A &&
                    wr_data[ccsr_pkg::B_SOFT_RST];     // R8
  assign to_default = off_state_i | soft_rst;
  assign boost_rise = boost_s & ~boost_q;

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      // Matches the synchroniser's reset level: no false edge after reset
      boost_q <= 1'b1;
    end else begin
      boost_q <= boost_s;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      ctrl_a <= ccsr_pkg::CTRL_A_RST;
    end else if (to_default) begin
      ctrl_a <= ccsr_pkg::CTRL_A_RST;                   // R8
    end else begin
      if (wr_stb && wr_addr == ccsr_pkg::OFS_CTRL_A) begin
        // Soft reset and timer restart bits are never stored
        ctrl_a <= wr_data & ccsr_pkg::CTRL_A_STORE;    // R9 R11 R12 R13 R15
      end
      if (charge_mode_enter_i) begin
        ctrl_a[ccsr_pkg::B_BOOST_REQ] <= 1'b0;          // R10
      end
      // Pin edge wins over a clear in the same cycle
      if (boost_rise) begin
        ctrl_a[ccsr_pkg::B_BOOST_REQ] <= 1'b1;          // R10
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      ctrl_b <= ccsr_pkg::CTRL_B_RST;
    end else if (to_default) begin
      ctrl_b <= ccsr_pkg::CTRL_B_RST;                   // R8
    end else if (wr_stb && wr_addr == ccsr_pkg::OFS_CTRL_B) begin
      ctrl_b <= wr_data;                                // R16 R17 R18 R19
    end else if (boost_mode_enter_i) begin
      // Boost entry restores all bits but the transceiver and flag mask bits
      ctrl_b <= {ccsr_pkg::CTRL_B_RST[7:5], ctrl_b[4:3],
                 ccsr_pkg::CTRL_B_RST[2:0]};             // R20 R21 R22
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      charge_timer_restart_o <= 1'b0;
    end else begin
      charge_timer_restart_o <= wr_stb && !to_default &&
                                wr_addr == ccsr_pkg::OFS_CTRL_A &&
                                wr_data[ccsr_pkg::B_TMR_RESTART]; // R14
    end
  end

  // ----------------------------------------
  // Status events, clear on read
  // ----------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      events <= ccsr_pkg::EVENTS_RST;
    end else if (to_default) begin
      events <= ccsr_pkg::EVENTS_RST;
    end else begin
      if (rd_stb && rd_addr == ccsr_pkg::OFS_EVENTS) begin
        events <= status_event_set_i & ccsr_pkg::EVENTS_VALID; // R25 R26
      end else begin
        events <= events |
                  (status_event_set_i & ccsr_pkg::EVENTS_VALID); // R26
      end
      if (boost_mode_enter_i &&
          !status_event_set_i[ccsr_pkg::B_VBUS_OK]) begin
        events[ccsr_pkg::B_VBUS_OK] <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Pins driven from control state
  // ----------------------------------------
  assign any_pending = (|events) | fault_event_pending_i;

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      irq_pin_n_o  <= 1'b1;
      flag_event_o <= 1'b0;
    end else begin
      irq_pin_n_o  <= ~(any_pending &
                        ~ctrl_a[ccsr_pkg::B_IRQ_MASK]);  // R15 R25
      flag_event_o <= any_pending &
                      ~ctrl_b[ccsr_pkg::B_FLAG_MASK];    // R19
    end
  end

  assign charging_allow_o         = ctrl_a[ccsr_pkg::B_CHG_ALLOW];
  assign host_boost_request_o     = ctrl_a[ccsr_pkg::B_BOOST_REQ];
  assign thermistor_profile_en_o  = ctrl_a[ccsr_pkg::B_THERM_EN];
  assign junction_heat_derate_o   = ctrl_a[ccsr_pkg::B_TJ_DERATE];
  assign force_end_of_charge_o    = ctrl_a[ccsr_pkg::B_FORCE_EOC];
  assign watchdog_off_o           = ctrl_b[ccsr_pkg::B_WDOG_OFF];
  assign charge_timer_off_o       = ctrl_b[ccsr_pkg::B_CTMR_OFF];
  assign power_route_enable_o     = ctrl_b[ccsr_pkg::B_ROUTE_EN];
  assign transceiver_supply_en_o  = ctrl_b[ccsr_pkg::B_XCVR_EN];
  assign input_limit_pin_select_o = ctrl_b[ccsr_pkg::B_LIM_PINSEL];
  assign input_limit_enable_o     = ctrl_b[ccsr_pkg::B_LIM_EN];
  assign adaptive_input_current_enable_o = ctrl_b[ccsr_pkg::B_ADAPT_EN];

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);

  property p_addr_ack;
    (st == ADDR && line.scl_fall && cnt == ccsr_pkg::LAST_DATA_BIT
     && addr_hit && !line.start && !line.stop) |=> sda_oe_o;
  endproperty
  a_addr_ack: assert property (p_addr_ack) // R1
    else $error("matching address not acknowledged");

  property p_addr_miss;
    (st == ADDR && line.scl_fall && cnt == ccsr_pkg::LAST_DATA_BIT
     && !addr_hit && !line.start && !line.stop)
    |=> (st == IDLE && !sda_oe_o);
  endproperty
  a_addr_miss: assert property (p_addr_miss) // R1
    else $error("foreign address answered");

  property p_state_load;
    (rd_stb && rd_addr == ccsr_pkg::OFS_STATUS)
    |-> tx[7:4] == $past(charge_state_i);
  endproperty
  a_state_load: assert property (p_state_load) // R2
    else $error("state field not loaded from charge state");

  property p_soft_rst;
    soft_rst |=> (ctrl_a == ccsr_pkg::CTRL_A_RST &&
                  ctrl_b == ccsr_pkg::CTRL_B_RST && events == 8'h00);
  endproperty
  a_soft_rst: assert property (p_soft_rst) // R8
    else $error("soft reset did not restore defaults");

  property p_boost_pin;
    (boost_rise && !to_default) |=> host_boost_request_o;
  endproperty
  a_boost_pin: assert property (p_boost_pin) // R10
    else $error("boost pin edge did not set request");

  property p_tmr_pulse;
    (wr_stb && !to_default && wr_addr == ccsr_pkg::OFS_CTRL_A
     && wr_data[ccsr_pkg::B_TMR_RESTART])
    |=> charge_timer_restart_o ##1 !charge_timer_restart_o;
  endproperty
  a_tmr_pulse: assert property (p_tmr_pulse) // R14
    else $error("timer restart not a single pulse");

  property p_irq_pin;
    (any_pending && !ctrl_a[ccsr_pkg::B_IRQ_MASK]) |=> !irq_pin_n_o;
  endproperty
  a_irq_pin: assert property (p_irq_pin) // R15
    else $error("pending event not shown on interrupt pin");

  property p_ptr_inc;
    wr_stb |-> ptr == wr_addr + 8'h01;
  endproperty
  a_ptr_inc: assert property (p_ptr_inc) // R23
    else $error("pointer did not advance after write");

  property p_clr_read;
    (rd_stb && rd_addr == ccsr_pkg::OFS_EVENTS && !to_default
     && status_event_set_i == 8'h00) |=> events == 8'h00;
  endproperty
  a_clr_read: assert property (p_clr_read) // R25
    else $error("events not cleared by read");

  property p_reserved;
    (events & ~ccsr_pkg::EVENTS_VALID) == 8'h00 &&
    !ctrl_a[ccsr_pkg::B_SOFT_RST];
  endproperty
  a_reserved: assert property (p_reserved) // R26
    else $error("reserved bit set");

  c_write: cover property (wr_stb ##[1:400] wr_stb);
  c_read: cover property (rd_stb && rd_addr == ccsr_pkg::OFS_EVENTS);
  c_soft: cover property (soft_rst);
  c_boost: cover property (boost_rise);

endmodule : ccsr_regs

// *** bench/ccsr_master.sv ***
module ccsr_master (
  output logic      scl_o,
  output logic      sda_o,
  input  wire logic sda_i
);
  timeunit 1ns;
  timeprecision 1ns;
  // Quarter of the 320 ns link period; outside START and STOP, SDA only moves while SCL is low
  localparam int Q = 80;

  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  task automatic start();
    sda_o = 1'b1;
    #(Q);
    scl_o = 1'b1;
    #(Q);
    sda_o = 1'b0;
    #(Q);
    scl_o = 1'b0;
  endtask : start

  // Sampled late in the high phase: the target answers some mclk after a fall
  task automatic bitx(input logic b, output logic r);
    #(Q);
    sda_o = b;
    #(Q);
    scl_o = 1'b1;
    #(2*Q-10);
    r = sda_i;
    #10;
    scl_o = 1'b0;
  endtask : bitx

  task automatic stop();
    #(Q);
    sda_o = 1'b0;
    #(Q);
    scl_o = 1'b1;
    #(Q);
    sda_o = 1'b1;
    #(2*Q);
  endtask : stop

  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(d[i], r);
    end
    bitx(1'b1, r);
    ack = ~r;
  endtask : wbyte

  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(1'b1, d[i]);
    end
    bitx(last, r);
  endtask : rbyte
endmodule : ccsr_master

// *** bench/tb.sv ***
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic       mclk_i = 1'b0;
  logic       rstn_i = 1'b0;
  logic       scl_l, m_sda, sda_o, sda_oe_o, trs, irq_n, flg;
  logic       ca6, ca5, ca4, ca3, ca2, wd, ct, pr, xc, ps, le, ae;
  logic       boost_pin = 1'b0;
  logic       chg_ent   = 1'b0;
  logic       bst_ent   = 1'b0;
  logic [3:0] state     = ccsr_pkg::ST_WAIT;
  logic       batfet    = 1'b1;
  logic       therm     = 1'b0;
  logic       fault     = 1'b0;
  logic [7:0] ev_set    = 8'h00;
  logic [7:0] rq [5];
  int         mismatches = 0;
  int         samples_checked = 0;
  int         n_rst = 0;
  // Open drain line with pull-up
  wire        sda = m_sda & (~sda_oe_o | sda_o);
  wire  [7:0] oa  = {ca6, ca5, ca4, ca3, ca2, irq_n, flg, 1'b0};
  wire  [7:0] ob  = {wd, ct, pr, xc, 1'b0, ps, le, ae};

  always #20 mclk_i = ~mclk_i;
  always @(posedge mclk_i) if (trs === 1'b1) n_rst++;

  ccsr_master ccsr_master_i (.scl_o(scl_l), .sda_o(m_sda), .sda_i(sda));

  ccsr_regs ccsr_regs_i (
    .mclk_i(mclk_i), .rstn_i(rstn_i), .scl_i(scl_l), .sda_i(sda),
    .sda_o(sda_o), .sda_oe_o(sda_oe_o), .boost_pin_i(boost_pin),
    .off_state_i(1'b0), .charge_mode_enter_i(chg_ent),
    .boost_mode_enter_i(bst_ent), .charge_state_i(state),
    .batfet_present_i(batfet), .thermistor_present_i(therm),
    .fault_event_pending_i(fault), .status_event_set_i(ev_set),
    .charging_allow_o(ca6), .host_boost_request_o(ca5),
    .thermistor_profile_en_o(ca4), .junction_heat_derate_o(ca3),
    .force_end_of_charge_o(ca2), .charge_timer_restart_o(trs),
    .watchdog_off_o(wd), .charge_timer_off_o(ct),
    .power_route_enable_o(pr), .transceiver_supply_en_o(xc),
    .input_limit_pin_select_o(ps), .input_limit_enable_o(le),
    .adaptive_input_current_enable_o(ae), .irq_pin_n_o(irq_n),
    .flag_event_o(flg)
  );

  // ----------------------------------------
  // Bus and check helpers
  // ----------------------------------------
  task automatic tk(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask : tk

  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string m);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic xb(input logic [7:0] d);
    logic k;
    ccsr_master_i.wbyte(d, k);
    chk({7'h00, k}, 8'h01, "ack");
  endtask : xb

  task automatic wr(input logic [7:0] p, a, b, input int n);
    ccsr_master_i.start();
    xb(8'h6C);
    xb(p);
    if (n > 0) xb(a);
    if (n > 1) xb(b);
    ccsr_master_i.stop();
  endtask : wr

  task automatic rd(input logic [7:0] p, input int n);
    wr(p, 8'h00, 8'h00, 0);
    ccsr_master_i.start();
    xb(8'h6D);
    for (int i = 0; i < n; i++) begin
      ccsr_master_i.rbyte(i == n - 1, rq[i]);
    end
    ccsr_master_i.stop();
  endtask : rd

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_defaults();
    rd(8'h00, 5);
    chk(rq[0], 8'h18, "status");
    chk(rq[1], 8'h51, "ctrl a");
    chk(rq[2], 8'h1E, "ctrl b");
    chk(rq[3], 8'h00, "events");
    chk(rq[4], 8'h00, "unmapped");
    chk(oa, 8'hA4, "ctrl a pins");
    chk(ob, 8'h16, "ctrl b pins");
    $display("defaults done");
  endtask : t_defaults

  task automatic t_write();
    wr(8'h01, 8'h3E, 8'hE1, 2);
    rd(8'h01, 2);
    chk(rq[0], 8'h3C, "ctrl a");
    chk(rq[1], 8'hE1, "ctrl b");
    chk(oa, 8'h7C, "ctrl a pins");
    chk(ob, 8'hE1, "ctrl b pins");
    chk(n_rst[7:0], 8'h01, "restart pulse");
    $display("write done");
  endtask : t_write

  task automatic t_events();
    ev_set = 8'h86;
    tk(1);
    ev_set = 8'h00;
    tk(3);
    chk(oa, 8'h7A, "irq and flag");
    rd(8'h00, 1);
    chk(rq[0], 8'h1A, "summary");
    rd(8'h03, 1);
    chk(rq[0], 8'h04, "events");
    tk(3);
    chk(oa, 8'h7C, "irq after read");
    fault = 1'b1;
    rd(8'h00, 1);
    chk(rq[0], 8'h19, "fault summary");
    fault = 1'b0;
    $display("events done");
  endtask : t_events

  task automatic t_boost();
    logic [3:0] c;
    chg_ent = 1'b1;
    tk(1);
    chg_ent = 1'b0;
    tk(2);
    chk({7'h00, ca5}, 8'h00, "boost cleared");
    boost_pin = 1'b1;
    tk(6);
    chk({7'h00, ca5}, 8'h01, "boost pin");
    boost_pin = 1'b0;
    bst_ent = 1'b1;
    tk(1);
    bst_ent = 1'b0;
    rd(8'h02, 1);
    chk(rq[0], 8'h06, "boost entry");
    for (int i = 0; i < 16; i++) begin
      c = i[3:0];
      if (c inside {4'h0, 4'h1, [4'h8:4'hF]}) begin
        state = c;
        therm = c[0];
        rd(8'h00, 1);
        chk(rq[0], {c, 1'b1, c[0], 2'b00}, "state");
      end
    end
    $display("boost done");
  endtask : t_boost

  task automatic t_sreset();
    logic k;
    wr(8'h01, 8'h80, 8'h00, 1);
    rd(8'h01, 2);
    chk(rq[0], 8'h51, "ctrl a");
    chk(rq[1], 8'h1E, "ctrl b");
    ccsr_master_i.start();
    ccsr_master_i.wbyte(8'h6E, k);
    ccsr_master_i.stop();
    chk({7'h00, k}, 8'h00, "foreign address");
    $display("soft reset done");
  endtask : t_sreset

  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : finish_test

  initial begin
    tk(8);
    rstn_i = 1'b1;
    tk(3);
    t_defaults();
    t_write();
    t_events();
    t_boost();
    t_sreset();
    finish_test();
  end

  initial begin
    #2000000;
    mismatches++;
    finish_test();
  end
endmodule : tb
